// ---- core/gpio_cfg_pkg.sv ----
// Constants shared by the serializer pin configuration logic
package gpio_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PIN_COUNT = 8;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_PINS_ONE_TWO = 6'h0e;
	localparam logic [5:0] IDX_PIN_THREE = 6'h0f;
	localparam logic [5:0] IDX_PINS_FIVE_SIX = 6'h10;
	localparam logic [5:0] IDX_PORT_CTRL = 6'h20;
	localparam logic [5:0] IDX_PIN_LEVEL = 6'h21;
	// Reset values
	localparam logic [7:0] RST_PINS_ONE_TWO = 8'h00;
	localparam logic [7:0] RST_PIN_THREE = 8'h00;
	localparam logic [7:0] RST_PINS_FIVE_SIX = 8'h00;
	localparam logic [7:0] RST_PORT_CTRL = 8'h00;
	// Field positions
	localparam int POS_PIN_ONE_MODE = 0;
	localparam int POS_PIN_ONE_VAL = 3;
	localparam int POS_PIN_TWO_MODE = 4;
	localparam int POS_PIN_TWO_VAL = 7;
	localparam int POS_PIN_THREE_MODE = 0;
	localparam int POS_PIN_THREE_VAL = 3;
	localparam int POS_PIN_FIVE_MODE = 0;
	localparam int POS_PIN_FIVE_VAL = 3;
	localparam int POS_PIN_SIX_MODE = 4;
	localparam int POS_PIN_SIX_VAL = 7;
	localparam int POS_SECOND_PORT_SELECT = 0;
	// Writable masks; other bits are reserved
	localparam logic [7:0] MASK_PINS_ONE_TWO = 8'hff;
	localparam logic [7:0] MASK_PIN_THREE = 8'h0f;
	localparam logic [7:0] MASK_PINS_FIVE_SIX = 8'hbb;
	localparam logic [7:0] MASK_PORT_CTRL = 8'h01;
	// Mode encodings
	localparam logic [1:0] MODE_LOW_FUNC = 2'h0;
	localparam logic [1:0] MODE_LOW_HIZ = 2'h2;
	localparam logic [2:0] MODE_OUTPUT = 3'h1;
	localparam logic [2:0] MODE_INPUT = 3'h3;
	localparam logic [2:0] MODE_REMOTE_HOLD = 3'h5;
	localparam logic [2:0] MODE_REMOTE_DEFAULT = 3'h7;
endpackage

// ---- core/gpio_pin_ctrl.sv ----
// Mode decode and remote level hold for one configurable pin
`timescale 1ns/1ps
module gpio_pin_ctrl
	import gpio_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Configuration
	input wire logic [2:0] mode,
	input wire logic out_value,
	input wire logic remote_allowed,
	// Link side
	input wire logic remote_level,
	input wire logic link_lost,
	// Decoded pin behaviour
	output logic drive_level,
	output logic drive_en,
	output logic func_active,
	output logic input_active
);
	logic held_level;

	// Last level seen while the link was up
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			held_level <= 1'b0;
		end else if (!link_lost) begin
			held_level <= remote_level;
		end
	end

	always_comb begin
		drive_level = 1'b0;
		drive_en = 1'b0;
		func_active = 1'b0;
		input_active = 1'b0;
		if (mode[1:0] == MODE_LOW_FUNC) begin
			func_active = 1'b1; // [RL1] [RL9]
		end else if (mode[1:0] == MODE_LOW_HIZ) begin
			drive_en = 1'b0; // [RL1] [RL9]
		end else if (mode == MODE_OUTPUT) begin
			drive_en = 1'b1; // [RL2] [RL5] [RL8] [RL9]
			drive_level = out_value;
		end else if (mode == MODE_INPUT) begin
			input_active = 1'b1; // [RL2] [RL9]
		end else if (mode == MODE_REMOTE_HOLD && remote_allowed) begin
			drive_en = 1'b1; // [RL3]
			drive_level = link_lost ? held_level : remote_level;
		end else if (mode == MODE_REMOTE_DEFAULT && remote_allowed) begin
			drive_en = 1'b1; // [RL4]
			drive_level = link_lost ? out_value : remote_level;
		end
	end
endmodule

// ---- core/serializer_gpio_config.sv ----
// Register block and pin drivers for the serializer general-purpose pins
//
// Summary of operation
// RL1 - Mode low bits 00 select functional input; 10 selects high impedance.
// RL2 - Mode 001 is local output; mode 011 is general-purpose input.
// RL3 - Mode 101 drives remote level, holding last level on link loss.
// RL4 - Mode 111 drives remote level, falling back to output-value on link loss.
// RL5 - Output-value drives the pin only in local output mode and in mode 111 on link loss.
// RL6 - Every output-value bit resets to 0; pins reset to functional mode, not driven.
// RL7 - Second-port select redirects pin one to three fields to the second port.
// RL8 - Pin six output-value at bit 7 drives it in output mode; no remote.
// RL9 - Two-bit pin five and six modes: 00 func, 10 hiz, 01 out, 11 in.
// RL10 - Reserved configuration bits read as zero and ignore writes.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module serializer_gpio_config
	import gpio_cfg_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [gpio_cfg_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [gpio_cfg_pkg::DATA_W-1:0] writedata,
	output logic [gpio_cfg_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	// First port pins one to three
	input wire logic [2:0] general_pin_in,
	output logic [2:0] general_pin_out,
	output logic [2:0] general_pin_oe,
	// Second port pins one to three
	input wire logic [2:0] second_port_pin_in,
	output logic [2:0] second_port_pin_out,
	output logic [2:0] second_port_pin_oe,
	// Pins five and six
	input wire logic general_pin_five_in,
	output logic general_pin_five_out,
	output logic general_pin_five_oe,
	input wire logic general_pin_six_in,
	output logic general_pin_six_out,
	output logic general_pin_six_oe,
	// Remote levels and link state from the back channel
	input wire logic [2:0] remote_level_first,
	input wire logic link_lost_first,
	input wire logic [2:0] remote_level_second,
	input wire logic link_lost_second,
	// Functional input paths
	output logic [2:0] func_in_first,
	output logic [2:0] func_in_second,
	output logic func_in_five,
	output logic func_in_six
);
	import gpio_cfg_pkg::*;

	// Per-port configuration of pins one to three, pins five and six, and port select
	logic [7:0] pins_one_two_first;
	logic [7:0] pins_one_two_second;
	logic [7:0] pin_three_first;
	logic [7:0] pin_three_second;
	logic [7:0] pins_five_six_config;
	logic second_port_select;

	// Bus state
	logic access_done;
	logic [5:0] reg_index;
	logic addr_aligned;
	logic write_taken;
	logic request_new;
	logic read_taken;
	logic wr_pins_one_two;
	logic wr_pin_three;
	logic wr_pins_five_six;
	logic wr_port_ctrl;
	logic [7:0] wdata_byte;
	logic [7:0] next_readdata;

	// Pin synchronisers
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;

	// Per-pin decode vectors, index 0-2 first port, 3-5 second, 6 pin five, 7 pin six
	logic [2:0] pin_mode [PIN_COUNT];
	logic [PIN_COUNT-1:0] pin_value;
	logic [PIN_COUNT-1:0] pin_remote_ok;
	logic [PIN_COUNT-1:0] pin_remote;
	logic [PIN_COUNT-1:0] pin_lost;
	logic [PIN_COUNT-1:0] next_level;
	logic [PIN_COUNT-1:0] next_oe;
	logic [PIN_COUNT-1:0] pin_func;

	assign reg_index = address[ADDR_W-1:2];
	assign addr_aligned = (address[1:0] == 2'h0);
	// A held request is new only while no answer is out for it
	assign request_new = (read || write) && waitrequest && !access_done;
	assign read_taken = read && request_new;
	assign write_taken = write && !waitrequest && byteenable[0] && addr_aligned;
	assign wdata_byte = writedata[7:0];

	// One write strobe per register
	assign wr_pins_one_two = write_taken && reg_index == IDX_PINS_ONE_TWO;
	assign wr_pin_three = write_taken && reg_index == IDX_PIN_THREE;
	assign wr_pins_five_six = write_taken && reg_index == IDX_PINS_FIVE_SIX;
	assign wr_port_ctrl = write_taken && reg_index == IDX_PORT_CTRL;

	// Slave answers one cycle after the request is raised
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			waitrequest <= 1'b1;
			access_done <= 1'b0;
		end else if (request_new) begin
			// Answer lasts one cycle so a write lands exactly once
			waitrequest <= 1'b0;
			access_done <= 1'b1;
		end else begin
			waitrequest <= 1'b1;
			access_done <= 1'b0;
		end
	end

	// Read mux; reserved and unmapped bits read zero
	always_comb begin
		next_readdata = 8'h00;
		if (addr_aligned) begin
			case (reg_index)
				IDX_PINS_ONE_TWO: begin
					next_readdata = (second_port_select ? pins_one_two_second :
						pins_one_two_first) & MASK_PINS_ONE_TWO; // [RL7]
				end
				IDX_PIN_THREE: begin
					next_readdata = (second_port_select ? pin_three_second :
						pin_three_first) & MASK_PIN_THREE; // [RL7] [RL10]
				end
				IDX_PINS_FIVE_SIX: begin
					next_readdata = pins_five_six_config & MASK_PINS_FIVE_SIX; // [RL10]
				end
				IDX_PORT_CTRL: begin
					next_readdata = {7'h00, second_port_select};
				end
				IDX_PIN_LEVEL: begin
					next_readdata = pin_sync;
				end
				default: begin
					next_readdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			readdata <= '0;
		end else if (read_taken) begin
			readdata <= {24'h000000, next_readdata};
		end
	end

	// First port bank of pins one to three
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pins_one_two_first <= RST_PINS_ONE_TWO; // [RL6]
			pin_three_first <= RST_PIN_THREE; // [RL6]
		end else if (!second_port_select) begin
			// Bank follows the select value standing at the write edge
			if (wr_pins_one_two) begin
				pins_one_two_first <= wdata_byte & MASK_PINS_ONE_TWO;
			end
			if (wr_pin_three) begin
				pin_three_first <= wdata_byte & MASK_PIN_THREE; // [RL10]
			end
		end
	end

	// Second port bank, written while the select bit is set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pins_one_two_second <= RST_PINS_ONE_TWO; // [RL6]
			pin_three_second <= RST_PIN_THREE; // [RL6]
		end else if (second_port_select) begin
			if (wr_pins_one_two) begin
				pins_one_two_second <= wdata_byte & MASK_PINS_ONE_TWO; // [RL7]
			end
			if (wr_pin_three) begin
				pin_three_second <= wdata_byte & MASK_PIN_THREE; // [RL7] [RL10]
			end
		end
	end

	// Pins five and six
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pins_five_six_config <= RST_PINS_FIVE_SIX; // [RL6]
		end else if (wr_pins_five_six) begin
			pins_five_six_config <= wdata_byte & MASK_PINS_FIVE_SIX; // [RL10]
		end
	end

	// Port selection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			second_port_select <= RST_PORT_CTRL[POS_SECOND_PORT_SELECT];
		end else if (wr_port_ctrl) begin
			second_port_select <= wdata_byte[POS_SECOND_PORT_SELECT];
		end
	end

	// Two-stage synchroniser on every pin input
	assign pin_raw = {general_pin_six_in, general_pin_five_in, second_port_pin_in,
		general_pin_in};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// Field routing into the per-pin decoders
	always_comb begin
		pin_mode[0] = pins_one_two_first[POS_PIN_ONE_MODE +: 3];
		pin_mode[1] = pins_one_two_first[POS_PIN_TWO_MODE +: 3];
		pin_mode[2] = pin_three_first[POS_PIN_THREE_MODE +: 3];
		pin_mode[3] = pins_one_two_second[POS_PIN_ONE_MODE +: 3];
		pin_mode[4] = pins_one_two_second[POS_PIN_TWO_MODE +: 3];
		pin_mode[5] = pin_three_second[POS_PIN_THREE_MODE +: 3];
		// Two-bit fields widened with a zero top bit
		pin_mode[6] = {1'b0, pins_five_six_config[POS_PIN_FIVE_MODE +: 2]}; // [RL9]
		pin_mode[7] = {1'b0, pins_five_six_config[POS_PIN_SIX_MODE +: 2]}; // [RL9]
		pin_value[0] = pins_one_two_first[POS_PIN_ONE_VAL];
		pin_value[1] = pins_one_two_first[POS_PIN_TWO_VAL];
		pin_value[2] = pin_three_first[POS_PIN_THREE_VAL];
		pin_value[3] = pins_one_two_second[POS_PIN_ONE_VAL];
		pin_value[4] = pins_one_two_second[POS_PIN_TWO_VAL];
		pin_value[5] = pin_three_second[POS_PIN_THREE_VAL];
		pin_value[6] = pins_five_six_config[POS_PIN_FIVE_VAL];
		pin_value[7] = pins_five_six_config[POS_PIN_SIX_VAL]; // [RL8]
	end

	// Pins five and six have no remote mode
	assign pin_remote_ok = 8'h3f; // [RL8]
	assign pin_remote = {2'h0, remote_level_second, remote_level_first};
	assign pin_lost = {2'h0, {3{link_lost_second}}, {3{link_lost_first}}};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			gpio_pin_ctrl u_pin (
				.clk_sys(clk_sys),
				.nrst(nrst),
				.mode(pin_mode[gi]),
				.out_value(pin_value[gi]),
				.remote_allowed(pin_remote_ok[gi]),
				.remote_level(pin_remote[gi]),
				.link_lost(pin_lost[gi]),
				.drive_level(next_level[gi]),
				.drive_en(next_oe[gi]),
				.func_active(pin_func[gi]),
				.input_active()
			);
		end
	endgenerate

	// Registered pin drivers
	// Levels and enables leave one flop so a mode change cannot glitch a pin
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			general_pin_out <= 3'h0;
			general_pin_oe <= 3'h0;
			second_port_pin_out <= 3'h0;
			second_port_pin_oe <= 3'h0;
			general_pin_five_out <= 1'b0;
			general_pin_five_oe <= 1'b0;
			general_pin_six_out <= 1'b0;
			general_pin_six_oe <= 1'b0;
		end else begin
			general_pin_out <= next_level[2:0]; // [RL5]
			general_pin_oe <= next_oe[2:0];
			second_port_pin_out <= next_level[5:3]; // [RL7]
			second_port_pin_oe <= next_oe[5:3];
			general_pin_five_out <= next_level[6];
			general_pin_five_oe <= next_oe[6];
			general_pin_six_out <= next_level[7]; // [RL8]
			general_pin_six_oe <= next_oe[7];
		end
	end

	// Functional input paths see the pin only in functional mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			func_in_first <= 3'h0;
			func_in_second <= 3'h0;
			func_in_five <= 1'b0;
			func_in_six <= 1'b0;
		end else begin
			func_in_first <= pin_sync[2:0] & pin_func[2:0]; // [RL1]
			func_in_second <= pin_sync[5:3] & pin_func[5:3];
			func_in_five <= pin_sync[6] & pin_func[6]; // [RL9]
			func_in_six <= pin_sync[7] & pin_func[7];
		end
	end
endmodule

// ---- tb/gpio_cfg_chk.sv ----
// Checker for the pin configuration block
`timescale 1ns/1ps
module gpio_cfg_chk
	import gpio_cfg_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [gpio_cfg_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [gpio_cfg_pkg::DATA_W-1:0] writedata,
	input wire logic [gpio_cfg_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	// Pins and link
	input wire logic [2:0] general_pin_out,
	input wire logic [2:0] general_pin_oe,
	input wire logic [2:0] func_in_first,
	input wire logic [2:0] remote_level_first,
	input wire logic link_lost_first
);
	logic [3:0] cfg;
	logic sel;
	logic [1:0] age;
	wire logic wr_ok = write && !waitrequest && byteenable[0];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Shadow of first-port pin one field and its age
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg <= 4'h0;
			age <= 2'h0;
		end else if (wr_ok && address == 8'h38 && !sel) begin
			cfg <= writedata[3:0];
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sel <= 1'b0;
		end else if (wr_ok && address == 8'h80) begin
			sel <= writedata[0];
		end
	end
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("answer too long");
	a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_func_quiet: assert property ((func_in_first & general_pin_oe) == 3'h0)
		else $error("functional pin driven");
	a_low_release: assert property (age == 2'h3 && !cfg[0] |-> !general_pin_oe[0])
		else $error("pin driven in x00 or x10");
	a_input_release: assert property (age == 2'h3 && cfg[2:0] == 3'h3 |-> !general_pin_oe[0])
		else $error("input pin driven");
	a_local_out: assert property (age == 2'h3 && cfg[2:0] == 3'h1
		|-> general_pin_oe[0] && general_pin_out[0] == cfg[3]) else $error("local out wrong");
	a_remote_live: assert property (age == 2'h3 && cfg[2] && cfg[0] && !$past(link_lost_first)
		|-> general_pin_oe[0] && general_pin_out[0] == $past(remote_level_first[0]))
		else $error("remote level not followed");
	a_remote_default: assert property (age == 2'h3 && cfg[2:0] == 3'h7 && $past(link_lost_first)
		|-> general_pin_out[0] == cfg[3]) else $error("default level wrong");
	a_remote_hold: assert property (age == 2'h3 && cfg[2:0] == 3'h5 && $past(link_lost_first)
		&& $past(link_lost_first, 2) |-> $stable(general_pin_out[0])) else $error("held level moved");
endmodule
bind serializer_gpio_config gpio_cfg_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.address(address), .read(read), .write(write), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.general_pin_out(general_pin_out), .general_pin_oe(general_pin_oe),
	.func_in_first(func_in_first), .remote_level_first(remote_level_first),
	.link_lost_first(link_lost_first));

// ---- tb/remote_deser_model.sv ----
// Behavioural back-channel partner driving remote levels and link state
`timescale 1ns/1ps
module remote_deser_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Link loss commands
	input wire logic lose_first,
	input wire logic lose_second,
	// Back-channel outputs
	output logic [2:0] remote_level_first,
	output logic [2:0] remote_level_second,
	output logic link_lost_first,
	output logic link_lost_second
);
	logic [2:0] cnt;
	// Levels keep changing during loss so stale data shows
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt <= 3'h0;
		end else begin
			cnt <= cnt + 3'h1;
		end
	end
	assign remote_level_first = cnt;
	assign remote_level_second = ~cnt;
	assign link_lost_first = lose_first;
	assign link_lost_second = lose_second;
endmodule

// ---- tb/serializer_gpio_config_tb.sv ----
// Self-checking bench for the pin configuration block
`timescale 1ns/1ps
module serializer_gpio_config_tb;
	import gpio_cfg_pkg::*;
	logic clk_sys, nrst = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
	logic lose_first = 1'b0, lose_second = 1'b0, five_in = 1'b1, six_in = 1'b0;
	logic five_out, five_oe, six_out, six_oe, f5, f6, ll1, ll2;
	logic [7:0] address = 8'h0, q, r;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0, readdata;
	logic [2:0] pin_in = 3'h5, sp_in = 3'h2, pin_out, pin_oe, sp_out, sp_oe, rl1, rl2, fi1, fi2;
	int fail_count, samples_checked;
	wire logic [7:0] oe_v = {3'h0, six_oe, five_oe, pin_oe};
	wire logic [7:0] out_v = {3'h0, six_out, five_out, pin_out} & oe_v;
	logic [7:0] ra [4] = '{8'h38, 8'h3c, 8'h40, 8'h80};
	logic [7:0] rm [2] = '{8'h05, 8'h0f};
	// Address, data, readback, pin enables, pin levels
	logic [39:0] rows [13] = '{40'h38_14_14_02_00, 40'h38_9a_9a_02_02, 40'h38_e9_e9_01_01,
		40'h38_b3_b3_00_00, 40'h38_1b_1b_02_00, 40'h3c_f9_09_06_04, 40'h3c_0e_0e_02_00,
		40'h40_ff_bb_02_00, 40'h40_99_99_1a_18, 40'h40_16_12_12_00, 40'h40_80_80_02_00,
		40'h44_ff_00_02_00, 40'h3a_ff_00_02_00};
	serializer_gpio_config DUT (.clk_sys(clk_sys), .nrst(nrst), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .general_pin_in(pin_in),
		.general_pin_out(pin_out), .general_pin_oe(pin_oe), .second_port_pin_in(sp_in),
		.second_port_pin_out(sp_out), .second_port_pin_oe(sp_oe),
		.general_pin_five_in(five_in), .general_pin_five_out(five_out),
		.general_pin_five_oe(five_oe), .general_pin_six_in(six_in),
		.general_pin_six_out(six_out), .general_pin_six_oe(six_oe),
		.remote_level_first(rl1), .link_lost_first(ll1), .remote_level_second(rl2),
		.link_lost_second(ll2), .func_in_first(fi1), .func_in_second(fi2),
		.func_in_five(f5), .func_in_six(f6));
	remote_deser_model u_remote (.clk_sys(clk_sys), .nrst(nrst), .lose_first(lose_first),
		.lose_second(lose_second), .remote_level_first(rl1), .remote_level_second(rl2),
		.link_lost_first(ll1), .link_lost_second(ll2));
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("MISMATCH %s exp %h got %h", n, e, g);
			fail_count++;
		end
	endtask
	// Avalon cycle held until waitrequest is low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] o);
		int n;
		@(posedge clk_sys);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= 4'h1;
		write <= w;
		read <= !w;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0);
		chk("answer cycles", 8'h2, n[7:0]);
		o = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 8'h0, q);
			chk("reset value", 8'h0, q);
		end
		bus(1'b0, 8'h84, 8'h0, q);
		chk("pin level", 8'h55, q);
		chk("func in", 8'h55, {f6, f5, fi2, fi1});
		chk("reset oe", 8'h0, oe_v);
		foreach (rows[i]) begin
			bus(1'b1, rows[i][39:32], rows[i][31:24], q);
			bus(1'b0, rows[i][39:32], 8'h0, q);
			chk("readback", rows[i][23:16], q);
			chk("pin oe", rows[i][15:8], oe_v);
			chk("pin out", rows[i][7:0], out_v);
		end
		chk("func gated", 8'h50, {f6, f5, fi2, fi1});
		bus(1'b1, 8'h80, 8'h1, q);
		bus(1'b1, 8'h38, 8'h09, q);
		bus(1'b0, 8'h38, 8'h0, q);
		chk("second bank", 8'h09, q);
		chk("second pins", 8'h11, {1'b0, sp_oe, 1'b0, sp_out & sp_oe});
		chk("first pins", 8'h02, oe_v);
		bus(1'b1, 8'h80, 8'h0, q);
		bus(1'b0, 8'h38, 8'h0, q);
		chk("first bank", 8'h1b, q);
		foreach (rm[i]) begin
			bus(1'b1, 8'h38, rm[i], q);
			repeat (2) @(negedge clk_sys);
			r = {5'h0, rl1};
			@(negedge clk_sys);
			chk("remote follow", {7'h0, r[0]}, {7'h0, pin_out[0]});
			while (rl1[0] === rm[i][3]) @(negedge clk_sys);
			@(posedge clk_sys);
			lose_first <= 1'b1;
			lose_second <= 1'b1;
			repeat (4) @(negedge clk_sys);
			chk("link lost", 8'h1, {7'h0, pin_out[0]});
			@(posedge clk_sys);
			lose_first <= 1'b0;
			lose_second <= 1'b0;
		end
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		bus(1'b0, 8'h38, 8'h0, q);
		chk("reset again", 8'h0, q);
		chk("reset pins", 8'h0, oe_v | {5'h0, sp_oe});
		summarize();
	end
endmodule
